// >>> verilog/fractional_baud_rate_generator.v
`include "baud_regs.vh"

// One prescaler plus fractional divider plus sample-per-bit counter
module baud_generator #(
   parameter INT_W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire osc_rise_i,
   input wire prescale_div4_i,
   input wire [INT_W-1:0] int_div_i,
   input wire [3:0] frac_div_i,
   input wire [1:0] mode_i,
   input wire restart_i,
   output reg sample_tick_o,
   output reg bit_tick_o,
   output wire running_o
);
   reg [1:0] pre_cnt;
   reg [INT_W:0] cnt;
   reg [3:0] acc;
   reg stretch;
   reg [3:0] smp_cnt;
   wire pre_tick;
   wire [INT_W:0] cnt_plus;
   wire [INT_W:0] period_len;
   wire [4:0] acc_sum;
   wire period_end;
   reg [3:0] smp_last;

   // Divide by 1 or by 4 ahead of the divider
   assign pre_tick = osc_rise_i & (~prescale_div4_i | (pre_cnt == `PRESCALE_LAST)); // R1
   assign cnt_plus = cnt + {{INT_W{1'b0}}, 1'b1};
   // Integer part plus one extra prescaled clock when the fraction carries
   assign period_len = {1'b0, int_div_i} + {{INT_W{1'b0}}, stretch}; // R13
   assign acc_sum = {1'b0, acc} + {1'b0, frac_div_i}; // R6
   // Zero integer divisor is outside the legal range and stops the generator
   assign running_o = (int_div_i != {INT_W{1'b0}}); // R2
   assign period_end = running_o & pre_tick & (cnt_plus == period_len);

   always @*
   begin
      case (mode_i) // R3
         `MODE_16X: smp_last = `LAST_16X;
         `MODE_8X: smp_last = `LAST_8X;
         `MODE_4X: smp_last = `LAST_4X;
         default: smp_last = `LAST_16X;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (rst_i | restart_i) // R12
      begin
         pre_cnt <= 2'h0;
         cnt <= {(INT_W+1){1'b0}};
         acc <= 4'h0;
         stretch <= 1'b0;
         smp_cnt <= 4'h0;
         sample_tick_o <= 1'b0;
         bit_tick_o <= 1'b0;
      end
      else
      begin
         if (osc_rise_i)
            pre_cnt <= pre_cnt + 2'h1;
         sample_tick_o <= period_end; // R9
         bit_tick_o <= 1'b0;
         if (period_end)
         begin
            cnt <= {(INT_W+1){1'b0}};
            acc <= acc_sum[3:0]; // R13
            stretch <= acc_sum[4]; // R13
            if (smp_cnt >= smp_last)
            begin
               smp_cnt <= 4'h0;
               bit_tick_o <= 1'b1; // R9
            end
            else
               smp_cnt <= smp_cnt + 4'h1;
         end
         else if (pre_tick & running_o)
            cnt <= cnt_plus;
      end
   end
endmodule

// One host-written register byte; its write strobe is delayed to line up with the restart
module reg_byte #(
   parameter [2:0] ADDR = 3'h0,
   parameter [7:0] INIT = 8'h00
) (
   input wire clk_i,
   input wire rst_i,
   input wire [2:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] value_o,
   output reg written_o
);
   wire hit;

   assign hit = reg_wr_i & (reg_addr_i == ADDR);

   always @(posedge clk_i)
   begin
      if (rst_i) // R12
      begin
         value_o <= INIT; // R4
         written_o <= 1'b0;
      end
      else
      begin
         // One-cycle strobe that restarts the generator fed by this byte
         written_o <= hit;
         // Bus writes need only clk_i, never the oscillator
         if (hit) // R11
            value_o <= reg_wdata_i;
      end
   end
endmodule

module fractional_baud_rate_generator (
   input wire clk_i,
   input wire rst_i,
   input wire osc_in_i,
   input wire [2:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   output wire tx_sample_tick_o,
   output wire tx_bit_tick_o,
   output wire rx_sample_tick_o,
   output wire rx_bit_tick_o
);
   wire [7:0] tx_low;
   wire [7:0] tx_high;
   wire [7:0] tx_frac;
   wire [7:0] rx_low;
   wire [7:0] rx_high;
   wire [7:0] rx_frac;
   wire [7:0] modem_control_register;
   wire tx_low_wr;
   wire tx_high_wr;
   wire tx_frac_wr;
   wire rx_low_wr;
   wire rx_high_wr;
   wire rx_frac_wr;
   wire ctrl_wr;
   reg osc_prev;
   wire tx_restart;
   wire rx_restart;
   reg [7:0] next_rdata;
   wire osc_rise;
   wire tx_running;
   wire rx_running;
   wire prescale_div4;

   // Oscillator input is sampled on clk_i; it must run at no more than half of clk_i
   assign osc_rise = osc_in_i & ~osc_prev; // R10
   assign prescale_div4 = modem_control_register[`MCR_PRESCALE_BIT]; // R1

   // A divisor write restarts its own path; a control write restarts both
   assign tx_restart = tx_low_wr | tx_high_wr | tx_frac_wr | ctrl_wr;
   assign rx_restart = rx_low_wr | rx_high_wr | rx_frac_wr | ctrl_wr;

   // Cleared previous sample: an input high at release counts as a rise
   always @(posedge clk_i)
   begin
      if (rst_i) // R12
         osc_prev <= 1'b0;
      else
         osc_prev <= osc_in_i;
   end

   // Register file runs on clk_i alone, so it works with the oscillator stopped
   // A write to the status address matches no byte and is ignored
   // Transmit divisor bytes
   reg_byte #(.ADDR(`ADDR_TX_LOW), .INIT(`RST_LOW)) tx_low_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(tx_low),
      .written_o(tx_low_wr)
   );

   reg_byte #(.ADDR(`ADDR_TX_HIGH), .INIT(`RST_HIGH)) tx_high_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(tx_high),
      .written_o(tx_high_wr)
   );

   reg_byte #(.ADDR(`ADDR_TX_FRAC), .INIT(`RST_FRAC)) tx_frac_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(tx_frac),
      .written_o(tx_frac_wr)
   );

   // Receive divisor bytes
   reg_byte #(.ADDR(`ADDR_RX_LOW), .INIT(`RST_LOW)) rx_low_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(rx_low),
      .written_o(rx_low_wr)
   );

   reg_byte #(.ADDR(`ADDR_RX_HIGH), .INIT(`RST_HIGH)) rx_high_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(rx_high),
      .written_o(rx_high_wr)
   );

   reg_byte #(.ADDR(`ADDR_RX_FRAC), .INIT(`RST_FRAC)) rx_frac_reg ( // R4
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(rx_frac),
      .written_o(rx_frac_wr)
   );

   // Prescale control, shared by both paths
   reg_byte #(.ADDR(`ADDR_MODEM_CTRL), .INIT(`RST_MODEM_CTRL)) ctrl_reg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .value_o(modem_control_register),
      .written_o(ctrl_wr)
   );

   always @*
   begin
      case (reg_addr_i)
         `ADDR_TX_LOW: next_rdata = tx_low;
         `ADDR_TX_HIGH: next_rdata = tx_high;
         `ADDR_TX_FRAC: next_rdata = tx_frac;
         `ADDR_RX_LOW: next_rdata = rx_low;
         `ADDR_RX_HIGH: next_rdata = rx_high;
         `ADDR_RX_FRAC: next_rdata = rx_frac;
         `ADDR_MODEM_CTRL: next_rdata = modem_control_register;
         `ADDR_STATUS: next_rdata = {6'h00, rx_running, tx_running};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data is registered and holds until the next read
   always @(posedge clk_i)
   begin
      if (rst_i) // R12
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
   end

   // Independent transmit and receive paths
   baud_generator #(.INT_W(16)) tx_gen ( // R8
      .clk_i(clk_i),
      .rst_i(rst_i),
      .osc_rise_i(osc_rise),
      .prescale_div4_i(prescale_div4),
      .int_div_i({tx_high, tx_low}), // R5
      .frac_div_i(tx_frac[`FRAC_MSB:`FRAC_LSB]), // R6
      .mode_i(tx_frac[`MODE_MSB:`MODE_LSB]), // R3
      .restart_i(tx_restart),
      .sample_tick_o(tx_sample_tick_o),
      .bit_tick_o(tx_bit_tick_o),
      .running_o(tx_running)
   );

   baud_generator #(.INT_W(16)) rx_gen ( // R8
      .clk_i(clk_i),
      .rst_i(rst_i),
      .osc_rise_i(osc_rise),
      .prescale_div4_i(prescale_div4),
      .int_div_i({rx_high, rx_low}), // R5
      .frac_div_i(rx_frac[`FRAC_MSB:`FRAC_LSB]), // R6
      .mode_i(rx_frac[`MODE_MSB:`MODE_LSB]), // R3
      .restart_i(rx_restart),
      .sample_tick_o(rx_sample_tick_o),
      .bit_tick_o(rx_bit_tick_o),
      .running_o(rx_running)
   );
endmodule

// >>> verilog/baud_regs.vh
`ifndef BAUD_REGS_VH
`define BAUD_REGS_VH
// Notes on behaviour
// R1 - Each generator input is the oscillator clock divided by 1 or 4, per control bit 7.
// R2 - Divisor runs from 1 to just under 65536 in sixteenth steps.
// R3 - Fraction register bits 5:4 choose 16, 8 or 4 samples per bit.
// R4 - After reset the divisor is one: low byte 0x01, high and fraction 0x00.
// R5 - Integer divisor is high byte times 256 plus low byte.
// R6 - Fraction register low nibble adds 0 to 15/16 to the divisor.
// R7 - Host writes the fraction field as truncated fraction times sixteen.
// R8 - Transmit and receive have separate generators, each with its own prescaler.
// R9 - Transmit shifts on the bit clock; receive samples on the sampling clock.
// R10 - Generators run from the oscillator input, crystal or external clock.
// R11 - Register access works with the oscillator stopped.
// R12 - Reset held over 40 ns restores all registers and outputs to defaults.
// R13 - Fraction realised by stretching chosen periods by one prescaled clock.

// Register addresses
`define ADDR_TX_LOW 3'h0
`define ADDR_TX_HIGH 3'h1
`define ADDR_TX_FRAC 3'h2
`define ADDR_RX_LOW 3'h3
`define ADDR_MODEM_CTRL 3'h4
`define ADDR_RX_HIGH 3'h5
`define ADDR_RX_FRAC 3'h6
`define ADDR_STATUS 3'h7

// Reset values
`define RST_LOW 8'h01
`define RST_HIGH 8'h00
`define RST_FRAC 8'h00
`define RST_MODEM_CTRL 8'h00

// Field positions
`define MCR_PRESCALE_BIT 7
`define FRAC_LSB 0
`define FRAC_MSB 3
`define MODE_LSB 4
`define MODE_MSB 5

// Sampling modes
`define MODE_16X 2'h0
`define MODE_8X 2'h1
`define MODE_4X 2'h2

// Sample counts per bit, minus one
`define LAST_16X 4'hf
`define LAST_8X 4'h7
`define LAST_4X 4'h3

// Prescale by four: last count of the two-bit prescaler
`define PRESCALE_LAST 2'h3

// Least reset time and its count of 20 ns cycles, rounded up
`define RESET_MIN_NS 40
`define CLK_PERIOD_NS 20
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> verif/baud_checker_asserts.sv
module baud_checker (
   input wire clk_i,
   input wire rst_i,
   input wire osc_in_i,
   input wire [2:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire tx_sample_tick_o,
   input wire tx_bit_tick_o,
   input wire rx_sample_tick_o,
   input wire rx_bit_tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr_low;
      reg_wr_i && reg_addr_i == 3'h0;
   endsequence
   sequence s_rd_low;
      reg_rd_i && !reg_wr_i && reg_addr_i == 3'h0;
   endsequence
   property p_readback;
      logic [7:0] d;
      (s_wr_low, d = reg_wdata_i) ##1 !reg_wr_i ##1 s_rd_low |=> reg_rdata_o == d;
   endproperty
   property p_tx_pulse;
      tx_sample_tick_o |=> !tx_sample_tick_o;
   endproperty
   property p_rx_pulse;
      rx_sample_tick_o |=> !rx_sample_tick_o;
   endproperty
   property p_tx_bit;
      tx_bit_tick_o |-> tx_sample_tick_o;
   endproperty
   property p_rx_bit;
      rx_bit_tick_o |-> rx_sample_tick_o;
   endproperty
   // At least four samples of two cycles each lie between bit ticks
   property p_bit_gap;
      tx_bit_tick_o |=> !tx_bit_tick_o [*7];
   endproperty
   property p_reset;
      $fell(rst_i) |-> !tx_sample_tick_o && !tx_bit_tick_o && !rx_sample_tick_o
         && !rx_bit_tick_o && reg_rdata_o == 8'h00;
   endproperty
   property p_hold;
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   a_readback: assert property (p_readback) else $error("read data differs from write");
   a_tx_pulse: assert property (p_tx_pulse) else $error("tx sample tick too long");
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx sample tick too long");
   a_tx_bit: assert property (p_tx_bit) else $error("tx bit tick off sample");
   a_rx_bit: assert property (p_rx_bit) else $error("rx bit tick off sample");
   a_bit_gap: assert property (p_bit_gap) else $error("tx bit ticks too close");
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule

bind fractional_baud_rate_generator baud_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .osc_in_i(osc_in_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .tx_sample_tick_o(tx_sample_tick_o),
   .tx_bit_tick_o(tx_bit_tick_o), .rx_sample_tick_o(rx_sample_tick_o),
   .rx_bit_tick_o(rx_bit_tick_o));

// >>> verif/osc_model.sv
module osc_model (
   input wire clk_i,
   input wire run_i,
   output logic osc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial osc_o = 1'b0;
   // External clock, one rise every two system cycles, stopped when not run
   always @(posedge clk_i)
      if (run_i)
         osc_o <= !osc_o;
endmodule

// >>> verif/test_fractional_baud_rate_generator.sv
module test_fractional_baud_rate_generator;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic run = 1'b0;
   logic osc;
   logic [2:0] addr = 3'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   wire tx_s, tx_b, rx_s, rx_b;
   int errors = 0;
   int comparisons = 0;
   int c, b;
   always #10 clk_i = !clk_i;
   osc_model i_osc (.clk_i(clk_i), .run_i(run), .osc_o(osc));
   fractional_baud_rate_generator i_dut (.clk_i(clk_i), .rst_i(rst_i), .osc_in_i(osc),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .tx_sample_tick_o(tx_s), .tx_bit_tick_o(tx_b),
      .rx_sample_tick_o(rx_s), .rx_bit_tick_o(rx_b));
   task complete_run;
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk8(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task chkn(string n, int e, int g);
      comparisons++;
      if (g != e)
      begin
         errors++;
         $display("MISMATCH %s exp %0d got %0d", n, e, g);
      end
   endtask
   // Both bus tasks are entered and left just after a rising edge
   task wr8(logic [2:0] a, logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd8(logic [2:0] a, logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      chk8("register", e, rdata);
      @(posedge clk_i);
   endtask
   // Cycles across 16 sample periods and bit ticks among them
   task measure(logic use_rx);
      int n, t;
      n = 0;
      t = 0;
      c = 0;
      b = 0;
      while (n < 17 && t < 10000)
      begin
         @(negedge clk_i);
         t++;
         if (n > 0)
            c++;
         if ((use_rx ? rx_s : tx_s) === 1'b1)
         begin
            n++;
            if (n > 1 && (use_rx ? rx_b : tx_b) === 1'b1)
               b++;
         end
      end
      if (n < 17)
      begin
         errors++;
         complete_run;
      end
      @(posedge clk_i);
   endtask
   task t_reset_values;
      logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03};
      for (int i = 0; i < 8; i++)
         rd8(i[2:0], rv[i]);
      wr8(3'h7, 8'h00);
      rd8(3'h7, 8'h03);
   endtask
   task t_fraction;
      run <= 1'b1;
      wr8(3'h0, 8'h03);
      rd8(3'h0, 8'h03);
      wr8(3'h2, 8'h08);
      wr8(3'h5, 8'h01);
      wr8(3'h3, 8'h00);
      measure(1'b0);
      chkn("tx period", 2 * (16 * 3 + 8), c);
      chkn("tx bits", 1, b);
      measure(1'b1);
      chkn("rx period", 2 * 16 * 256, c);
      chkn("rx bits", 1, b);
   endtask
   task t_modes;
      wr8(3'h0, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         wr8(3'h2, 8'(m << 4));
         measure(1'b0);
         chkn("mode period", 32, c);
         chkn("mode bits", (m == 3) ? 1 : 1 << m, b);
      end
   endtask
   task t_prescale;
      wr8(3'h4, 8'h80);
      measure(1'b0);
      chkn("div4 period", 2 * 4 * 16, c);
      wr8(3'h4, 8'h00);
      wr8(3'h0, 8'h00);
      rd8(3'h7, 8'h02);
   endtask
   // Reset in mid-run with the oscillator still running
   task t_reset_mid;
      wr8(3'h6, 8'h2a);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd8(3'h0, 8'h01);
      rd8(3'h6, 8'h00);
      rd8(3'h7, 8'h03);
   endtask
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_fraction();
      t_modes();
      t_prescale();
      t_reset_mid();
      complete_run;
   end
endmodule
